// file: rtl/evtp_egress_policy.sv
// egress tagging policy and per-queue egress pacing, with register file
// assumes an Avalon-MM master on the core clock and a packet pipeline
// that asks for one tagging decision per departing packet
//
// Contract
// - dumb: pass regular, strip special tags
// - access: strip every tag, special included
// - hybrid: insert, strip, change by port bits
// - processor: add special tag naming source port
// - type fields at 17:16, 9:8, 1:0, reset zero
// - hybrid bits per port; 15, 7 reserved
// - two 13-bit rates per pacing word
// - byte interval is (value plus one) times 20 ns
// - separate rate per queue, fixed register placement
// - rates reset zero; pacing gated by global enable
// - larger value gives slower queue
// - select bit picks ingress or egress defaults
// - insert tag only when untag bit clear
// - change vid needs change tag; priority tags always
// - change priority; untag bit strips instead
`timescale 1ns/1ps
`include "evtp_map.svh"
module evtp_egress_policy
   import evtp_pkg::*;
#(
   parameter int RATE_W = 13,
   parameter int NUM_Q = 6
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic dec_valid,
   input wire logic [1:0] dec_egress_port,
   input wire logic [1:0] dec_source_port,
   input wire logic [1:0] dec_tag_kind,
   input wire logic dec_vlan_untag,
   input wire logic [11:0] dec_ingress_vid,
   input wire logic [2:0] dec_ingress_pri,
   input wire logic [11:0] dec_egress_vid,
   input wire logic [2:0] dec_egress_pri,
   output logic act_valid,
   output logic act_strip,
   output logic act_insert,
   output logic act_set_vid,
   output logic act_set_pri,
   output logic act_add_special,
   output logic [11:0] act_vid,
   output logic [2:0] act_pri,
   output logic [1:0] act_source_port,
   input wire logic [NUM_Q-1:0] q_byte_valid,
   output logic [NUM_Q-1:0] q_byte_ready
);

   ////////////////////////////////////////////////////////////////////
   // register file
   logic [31:0] policy_reg; // egress_tagging_policy
   logic [31:0] pace_reg [3]; // three pacing words
   logic [31:0] ctrl_reg; // pacing enable, stands in for the global one
   logic [NUM_Q-1:0] q_busy; // per-queue pacer waiting
   evtp_bus_e bus_reg, bus_next; // slave state
   logic [31:0] rdata_reg; // read data, stable while acked
   logic [1:0] resp_reg; // answer code

   // address decode
   wire logic req_w;
   wire logic hit_policy;
   wire logic hit_pace0;
   wire logic hit_pace1;
   wire logic hit_pace2;
   wire logic hit_ctrl;
   wire logic hit_stat;
   wire logic hit_any;
   wire logic wr_take; // write takes effect this edge
   wire logic [31:0] be_mask; // byte lanes being written
   wire logic [31:0] rd_mux; // selected read value
   assign req_w = avs_read || avs_write;
   assign hit_policy = (avs_address == `EVTP_ADDR_POLICY);
   assign hit_pace0 = (avs_address == `EVTP_ADDR_PACE_P0Q01);
   assign hit_pace1 = (avs_address == `EVTP_ADDR_PACE_P0Q23);
   assign hit_pace2 = (avs_address == `EVTP_ADDR_PACE_P1Q01);
   assign hit_ctrl = (avs_address == `EVTP_ADDR_PACE_CTRL);
   assign hit_stat = (avs_address == `EVTP_ADDR_PACE_STAT);
   assign hit_any = hit_policy || hit_pace0 || hit_pace1 || hit_pace2 ||
      hit_ctrl || hit_stat;
   assign wr_take = avs_write && (bus_reg == BUS_ACK);
   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // reserved bits read as zero because they never store
   assign rd_mux = hit_policy ? policy_reg :
      hit_pace0 ? pace_reg[0] :
      hit_pace1 ? pace_reg[1] :
      hit_pace2 ? pace_reg[2] :
      hit_ctrl ? ctrl_reg :
      hit_stat ? {{(32 - NUM_Q){1'b0}}, q_busy} : 32'h00000000;

   // one wait state: every access is answered in the second cycle
   assign avs_waitrequest = req_w && (bus_reg != BUS_ACK);
   assign avs_readdata = rdata_reg;
   assign avs_response = resp_reg;

   // slave state
   always_comb begin
      bus_next = bus_reg;
      case (bus_reg)
         BUS_IDLE: begin
            if (req_w) begin
               bus_next = BUS_ACK;
            end
         end
         BUS_ACK: begin
            bus_next = BUS_IDLE;
         end
         default: begin
            bus_next = BUS_IDLE;
         end
      endcase
   end

   // slave registers; read data captured a cycle ahead of the answer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_reg <= BUS_IDLE;
         rdata_reg <= 32'h00000000;
         resp_reg <= `EVTP_RESP_OK;
      end else begin
         bus_reg <= bus_next;
         if (req_w && bus_reg == BUS_IDLE) begin
            rdata_reg <= avs_read ? rd_mux : 32'h00000000;
            resp_reg <= hit_any ? `EVTP_RESP_OK : `EVTP_RESP_ERR;
         end
      end
   end

   // writable registers; unmapped and status writes are dropped
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         policy_reg <= `EVTP_POLICY_RST;
         pace_reg[0] <= `EVTP_PACE_RST;
         pace_reg[1] <= `EVTP_PACE_RST;
         pace_reg[2] <= `EVTP_PACE_RST;
         ctrl_reg <= `EVTP_CTRL_RST;
      end else if (wr_take) begin
         if (hit_policy)
            policy_reg <= ((policy_reg & ~be_mask) | (avs_writedata & be_mask))
               & `EVTP_POLICY_MASK;
         if (hit_pace0)
            pace_reg[0] <= ((pace_reg[0] & ~be_mask) | (avs_writedata & be_mask))
               & `EVTP_PACE_MASK;
         if (hit_pace1)
            pace_reg[1] <= ((pace_reg[1] & ~be_mask) | (avs_writedata & be_mask))
               & `EVTP_PACE_MASK;
         if (hit_pace2)
            pace_reg[2] <= ((pace_reg[2] & ~be_mask) | (avs_writedata & be_mask))
               & `EVTP_PACE_MASK;
         if (hit_ctrl)
            ctrl_reg <= ((ctrl_reg & ~be_mask) | (avs_writedata & be_mask))
               & `EVTP_CTRL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // queue pacers: even queue in the low field, odd queue above it
   genvar gq;
   generate
      for (gq = 0; gq < NUM_Q; gq++) begin : g_pace
         localparam int LSB = (gq % 2 == 0) ? `EVTP_RATE_EVEN_LSB : `EVTP_RATE_ODD_LSB;
         evtp_pacer #(.RATE_W(RATE_W), .TICK(`EVTP_TICK_CYCLES)) u_pacer (
            .clock(clock),
            .resetn(resetn),
            .pace_en(ctrl_reg[0]),
            .rate(pace_reg[gq / 2][LSB +: RATE_W]),
            .byte_valid(q_byte_valid[gq]),
            .byte_ready(q_byte_ready[gq]),
            .busy(q_busy[gq])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // tagging decision for one departing packet
   wire logic [7:0] pfield; // policy byte of the egress port
   wire evtp_egress_e ptype;
   wire evtp_tag_e kind;
   wire logic f_sel;
   wire logic f_ins;
   wire logic f_cvid;
   wire logic f_cpri;
   wire logic f_ctag;
   // port 3 does not exist: its field reads as dumb
   assign pfield = (dec_egress_port == 2'h2) ? policy_reg[23:16] :
      (dec_egress_port == 2'h1) ? policy_reg[15:8] :
      (dec_egress_port == 2'h0) ? policy_reg[7:0] : 8'h00;
   assign ptype = evtp_egress_e'(pfield[`EVTP_F_TYPE_LSB +: 2]);
   assign kind = evtp_tag_e'(dec_tag_kind);
   assign f_sel = pfield[`EVTP_F_SELECT];
   assign f_ins = pfield[`EVTP_F_INSERT];
   assign f_cvid = pfield[`EVTP_F_CHG_VID];
   assign f_cpri = pfield[`EVTP_F_CHG_PRI];
   assign f_ctag = pfield[`EVTP_F_CHG_TAG];

   logic strip_next, insert_next, svid_next, spri_next, special_next;

   // decision by egress type and tag kind
   always_comb begin
      strip_next = 1'b0;
      insert_next = 1'b0;
      svid_next = 1'b0;
      spri_next = 1'b0;
      special_next = 1'b0;
      case (ptype)
         EG_DUMB: begin
            strip_next = (kind == TK_SPECIAL);
         end
         EG_ACCESS: begin
            strip_next = (kind != TK_UNTAGGED);
         end
         EG_HYBRID: begin
            case (kind)
               TK_UNTAGGED: begin
                  insert_next = f_ins && !dec_vlan_untag;
               end
               TK_PRIORITY: begin
                  svid_next = 1'b1;
                  spri_next = f_cpri;
               end
               TK_REGULAR: begin
                  // a set untag bit removes rather than rewrites
                  strip_next = dec_vlan_untag;
                  svid_next = !dec_vlan_untag && f_cvid && f_ctag;
                  spri_next = !dec_vlan_untag && f_cpri && f_ctag;
               end
               default: begin
                  strip_next = 1'b1; // special tags never leave a hybrid port
               end
            endcase
         end
         EG_CPU: begin
            special_next = 1'b1;
         end
         default: begin
            strip_next = 1'b0;
         end
      endcase
   end

   // decision registers: one cycle after the request
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         act_valid <= 1'b0;
         act_strip <= 1'b0;
         act_insert <= 1'b0;
         act_set_vid <= 1'b0;
         act_set_pri <= 1'b0;
         act_add_special <= 1'b0;
         act_vid <= 12'h000;
         act_pri <= 3'h0;
         act_source_port <= 2'h0;
      end else begin
         act_valid <= dec_valid;
         act_strip <= dec_valid && strip_next;
         act_insert <= dec_valid && insert_next;
         act_set_vid <= dec_valid && svid_next;
         act_set_pri <= dec_valid && spri_next;
         act_add_special <= dec_valid && special_next;
         act_vid <= f_sel ? dec_egress_vid : dec_ingress_vid;
         act_pri <= f_sel ? dec_egress_pri : dec_ingress_pri;
         act_source_port <= dec_source_port;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_req_hybrid;
      dec_valid && ptype == EG_HYBRID;
   endsequence
   chk_dumb_pass: assert property (@(posedge clock) disable iff (!resetn)
      dec_valid && ptype == EG_DUMB |=> act_valid &&
      (act_strip == ($past(dec_tag_kind) == 2'h3)) && !act_insert && !act_add_special)
      else $error("dumb port altered a packet wrongly");
   chk_access_strip: assert property (@(posedge clock) disable iff (!resetn)
      dec_valid && ptype == EG_ACCESS && kind != TK_UNTAGGED |=> act_strip)
      else $error("access port kept a tag");
   chk_cpu_special: assert property (@(posedge clock) disable iff (!resetn)
      dec_valid && ptype == EG_CPU |=> act_add_special &&
      act_source_port == $past(dec_source_port))
      else $error("processor port missed the special tag");
   chk_hybrid_insert: assert property (@(posedge clock) disable iff (!resetn)
      s_req_hybrid ##0 (kind == TK_UNTAGGED) |=>
      act_insert == ($past(f_ins) && !$past(dec_vlan_untag)))
      else $error("hybrid insert decision wrong");
   chk_hybrid_vid: assert property (@(posedge clock) disable iff (!resetn)
      s_req_hybrid ##0 (kind == TK_PRIORITY) |=> act_set_vid && !act_strip)
      else $error("priority-tagged packet kept its VLAN ID");
   chk_hybrid_pri: assert property (@(posedge clock) disable iff (!resetn)
      s_req_hybrid ##0 (kind == TK_REGULAR) ##0 dec_vlan_untag |=>
      act_strip && !act_set_pri && !act_set_vid)
      else $error("untag bit did not strip a regular tag");
   chk_select_src: assert property (@(posedge clock) disable iff (!resetn)
      dec_valid && f_sel |=> act_vid == $past(dec_egress_vid) &&
      act_pri == $past(dec_egress_pri))
      else $error("select bit did not pick egress defaults");
   chk_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
      (policy_reg & ~`EVTP_POLICY_MASK) == 32'h0 && (pace_reg[0] & ~`EVTP_PACE_MASK) == 32'h0)
      else $error("reserved bits stored a value");
   chk_bus_answer: assert property (@(posedge clock) disable iff (!resetn)
      req_w && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not in the second cycle");
   chk_pace_write: assert property (@(posedge clock) disable iff (!resetn)
      wr_take && hit_pace0 && avs_byteenable == 4'hF |=>
      pace_reg[0] == ($past(avs_writedata) & `EVTP_PACE_MASK))
      else $error("pacing word not written");
endmodule

// file: rtl/evtp_map.svh
// egress tagging policy and pacing: offsets, fields, resets, timing
// assumes a 32-bit register bus addressed in bytes, one word per register
`ifndef EVTP_MAP_SVH
`define EVTP_MAP_SVH
// register indices; the byte address is four times the index
`define EVTP_IDX_POLICY 16'h1C0C
`define EVTP_IDX_PACE_P0Q01 16'h1C0D
`define EVTP_IDX_PACE_P0Q23 16'h1C0E
`define EVTP_IDX_PACE_P1Q01 16'h1C0F
`define EVTP_IDX_PACE_CTRL 16'h1C20
`define EVTP_IDX_PACE_STAT 16'h1C21
`define EVTP_ADDR_POLICY (`EVTP_IDX_POLICY * 16'h0004)
`define EVTP_ADDR_PACE_P0Q01 (`EVTP_IDX_PACE_P0Q01 * 16'h0004)
`define EVTP_ADDR_PACE_P0Q23 (`EVTP_IDX_PACE_P0Q23 * 16'h0004)
`define EVTP_ADDR_PACE_P1Q01 (`EVTP_IDX_PACE_P1Q01 * 16'h0004)
`define EVTP_ADDR_PACE_CTRL (`EVTP_IDX_PACE_CTRL * 16'h0004)
`define EVTP_ADDR_PACE_STAT (`EVTP_IDX_PACE_STAT * 16'h0004)
// writable bits; everything else reads as zero
`define EVTP_POLICY_MASK 32'h007F7F7F
`define EVTP_PACE_MASK 32'h03FFFFFF
`define EVTP_CTRL_MASK 32'h00000001
// reset values
`define EVTP_POLICY_RST 32'h00000000
`define EVTP_PACE_RST 32'h00000000
`define EVTP_CTRL_RST 32'h00000000
// per-port policy field: base bit is 8 times the port number
`define EVTP_F_TYPE_LSB 0
`define EVTP_F_CHG_TAG 2
`define EVTP_F_CHG_PRI 3
`define EVTP_F_CHG_VID 4
`define EVTP_F_INSERT 5
`define EVTP_F_SELECT 6
// pacing rate fields inside a pacing word
`define EVTP_RATE_EVEN_LSB 0
`define EVTP_RATE_ODD_LSB 13
// pacing tick: time per count step and clock period
`define EVTP_TICK_NS 20
`define EVTP_CLK_NS 10
`define EVTP_TICK_CYCLES (`EVTP_TICK_NS / `EVTP_CLK_NS)
// bus answer codes
`define EVTP_RESP_OK 2'h0
`define EVTP_RESP_ERR 2'h2
`endif

// file: rtl/evtp_pkg.sv
// types for the egress tagging policy and pacing block
// assumes nothing beyond a SystemVerilog compiler
package evtp_pkg;
   // egress port type encoding
   typedef enum logic [1:0] {
      EG_DUMB = 2'h0,
      EG_ACCESS = 2'h1,
      EG_HYBRID = 2'h2,
      EG_CPU = 2'h3
   } evtp_egress_e;
   // tag carried by a departing packet
   typedef enum logic [1:0] {
      TK_UNTAGGED = 2'h0,
      TK_PRIORITY = 2'h1,
      TK_REGULAR = 2'h2,
      TK_SPECIAL = 2'h3
   } evtp_tag_e;
   // bus slave states, one-hot
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } evtp_bus_e;
   // pacer states, one-hot
   typedef enum logic [1:0] {
      PACE_IDLE = 2'b01,
      PACE_WAIT = 2'b10
   } evtp_pace_e;
endpackage

// file: rtl/evtp_pacer.sv
// one queue pacer: spaces byte releases by (rate + 1) pacing ticks
// assumes valid/ready from the queue and a rate from the register file
`timescale 1ns/1ps
`include "evtp_map.svh"
module evtp_pacer
   import evtp_pkg::*;
#(
   parameter int RATE_W = 13,
   parameter int TICK = `EVTP_TICK_CYCLES
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic pace_en,
   input wire logic [RATE_W-1:0] rate,
   input wire logic byte_valid,
   output logic byte_ready,
   output logic busy
);
   evtp_pace_e state_reg, state_next; // pacer state
   logic [RATE_W-1:0] cnt_reg, cnt_next; // ticks left
   logic [7:0] pre_reg, pre_next; // cycles left in this tick
   logic [15:0] len_reg; // helper: cycles spent waiting
   logic [RATE_W-1:0] hold_reg; // helper: rate taken at release
   wire logic release_w;

   // a byte leaves when pacing is on and the counter has expired
   assign release_w = byte_valid && pace_en && (state_reg == PACE_IDLE);
   assign byte_ready = !pace_en || (state_reg == PACE_IDLE);
   assign busy = (state_reg == PACE_WAIT);

   ////////////////////////////////////////////////////////////////////
   // down-counter, one step per pacing tick
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pre_next = pre_reg;
      case (state_reg)
         PACE_IDLE: begin
            if (release_w) begin
               state_next = PACE_WAIT;
               cnt_next = rate;
               pre_next = 8'(TICK - 1);
            end
         end
         PACE_WAIT: begin
            // switching pacing off frees the queue at once
            if (!pace_en) begin
               state_next = PACE_IDLE;
            end else if (pre_reg != 8'h00) begin
               pre_next = pre_reg - 8'h01;
            end else if (cnt_reg == '0) begin
               state_next = PACE_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
               pre_next = 8'(TICK - 1);
            end
         end
         default: begin
            state_next = PACE_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= PACE_IDLE;
         cnt_reg <= '0;
         pre_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
      end
   end

   // helper: measure each wait for the checks below
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         len_reg <= 16'h0000;
         hold_reg <= '0;
      end else if (release_w) begin
         len_reg <= 16'h0000;
         hold_reg <= rate;
      end else if (busy) begin
         len_reg <= len_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_wait_ends;
      busy && pace_en && (state_next == PACE_IDLE);
   endsequence
   chk_pace_interval: assert property (@(posedge clock) disable iff (!resetn)
      s_wait_ends |-> (32'(len_reg) + 1 == (32'(hold_reg) + 1) * TICK))
      else $error("pacing interval differs from (rate+1) ticks");
   chk_pace_blocks: assert property (@(posedge clock) disable iff (!resetn)
      release_w |=> !byte_ready [*2])
      else $error("queue released a byte before its counter expired");
   chk_pace_off: assert property (@(posedge clock) disable iff (!resetn)
      !pace_en |-> byte_ready)
      else $error("queue held while pacing is off");
endmodule

// file: verif/evtp_testbench.sv
// self-checking bench for the egress tagging policy and pacing block
// assumes the design files and evtp_map.svh are compiled before this file
`timescale 1ns/1ps
`include "evtp_map.svh"
module testbench;
   import evtp_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF; // full words, one lane-masked write below
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic dec_valid = 1'b0;
   logic [1:0] dec_egress_port = 2'h0;
   logic [1:0] dec_source_port = 2'h0;
   logic [1:0] dec_tag_kind = 2'h0;
   logic dec_vlan_untag = 1'b0;
   logic [11:0] dec_ingress_vid = 12'h123; // distinct defaults show which was chosen
   logic [2:0] dec_ingress_pri = 3'h5;
   logic [11:0] dec_egress_vid = 12'hABC;
   logic [2:0] dec_egress_pri = 3'h2;
   logic act_valid, act_strip, act_insert, act_set_vid, act_set_pri, act_add_special;
   logic [11:0] act_vid;
   logic [2:0] act_pri;
   logic [1:0] act_source_port;
   logic [5:0] q_byte_valid = 6'h00;
   logic [5:0] q_byte_ready;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] policy; // last policy word written, for expected defaults

   evtp_egress_policy dut_u (.clock(clock), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .dec_valid(dec_valid),
      .dec_egress_port(dec_egress_port), .dec_source_port(dec_source_port),
      .dec_tag_kind(dec_tag_kind), .dec_vlan_untag(dec_vlan_untag),
      .dec_ingress_vid(dec_ingress_vid), .dec_ingress_pri(dec_ingress_pri),
      .dec_egress_vid(dec_egress_vid), .dec_egress_pri(dec_egress_pri),
      .act_valid(act_valid), .act_strip(act_strip), .act_insert(act_insert),
      .act_set_vid(act_set_vid), .act_set_pri(act_set_pri),
      .act_add_special(act_add_special), .act_vid(act_vid), .act_pri(act_pri),
      .act_source_port(act_source_port), .q_byte_valid(q_byte_valid),
      .q_byte_ready(q_byte_ready));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      forever #5 clock = ~clock;
   end
   // ceiling well above the 140 or so cycles the tests need
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge
   task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
      avs_write <= 1'b1;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      avs_read <= 1'b1;
      avs_address <= a;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      r = avs_response;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      bus_rd(a, d, r);
      chk(d, exp, "read data");
      chk({30'h0, r}, {30'h0, er}, "response");
   endtask
   task automatic set_policy(input logic [31:0] p);
      policy = p;
      bus_wr(`EVTP_ADDR_POLICY, p);
   endtask
   // one decision; flags ordered strip, insert, set_vid, set_pri, add_special
   task automatic dec_chk(input logic [1:0] port, input logic [1:0] kind, input logic untag,
      input logic [4:0] exp);
      logic sel;
      sel = policy[8 * port + 6];
      dec_valid <= 1'b1;
      dec_egress_port <= port;
      dec_source_port <= ~port;
      dec_tag_kind <= kind;
      dec_vlan_untag <= untag;
      @(posedge clock);
      dec_valid <= 1'b0;
      @(posedge clock);
      chk({31'h0, act_valid}, 32'h1, "decision valid");
      chk({27'h0, act_strip, act_insert, act_set_vid, act_set_pri, act_add_special},
         {27'h0, exp}, "decision flags");
      chk({17'h0, act_pri, act_vid}, sel ? {17'h0, dec_egress_pri, dec_egress_vid} :
         {17'h0, dec_ingress_pri, dec_ingress_vid}, "tag defaults");
      chk({30'h0, act_source_port}, {30'h0, ~port}, "source port");
   endtask
   // one byte released, then the ready gap is counted in cycles
   task automatic pace_chk(input int q, input int rate);
      int n;
      q_byte_valid[q] <= 1'b1;
      do @(posedge clock); while (q_byte_ready[q] !== 1'b1);
      q_byte_valid[q] <= 1'b0;
      n = 0;
      @(posedge clock);
      while (q_byte_ready[q] === 1'b0) begin
         n = n + 1;
         @(posedge clock);
      end
      chk(n, (rate + 1) * `EVTP_TICK_CYCLES, "pacing gap");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      // reset values, then reserved bits and an unmapped place
      rd_chk(`EVTP_ADDR_POLICY, 32'h0, 2'h0);
      rd_chk(`EVTP_ADDR_PACE_P0Q01, 32'h0, 2'h0);
      rd_chk(`EVTP_ADDR_PACE_P0Q23, 32'h0, 2'h0);
      rd_chk(`EVTP_ADDR_PACE_P1Q01, 32'h0, 2'h0);
      chk({26'h0, q_byte_ready}, 32'h3F, "ready with pacing off");
      set_policy(32'hFFFFFFFF);
      rd_chk(`EVTP_ADDR_POLICY, 32'h007F7F7F, 2'h0);
      bus_wr(`EVTP_ADDR_PACE_P0Q23, 32'hFFFFFFFF);
      rd_chk(`EVTP_ADDR_PACE_P0Q23, 32'h03FFFFFF, 2'h0);
      // only byte lane 1 written: the other lanes keep their ones
      avs_byteenable <= 4'h2;
      bus_wr(`EVTP_ADDR_PACE_P0Q23, 32'h00000000);
      avs_byteenable <= 4'hF;
      rd_chk(`EVTP_ADDR_PACE_P0Q23, 32'h03FF00FF, 2'h0);
      rd_chk(16'h7100, 32'h0, 2'h2);
      $display("test registers done");
      // dumb port 0, access port 1, processor port 2
      set_policy(32'h00030100);
      dec_chk(2'h0, 2'h2, 1'b0, 5'b00000);
      dec_chk(2'h0, 2'h3, 1'b0, 5'b10000);
      dec_chk(2'h1, 2'h2, 1'b0, 5'b10000);
      dec_chk(2'h1, 2'h3, 1'b0, 5'b10000);
      dec_chk(2'h1, 2'h0, 1'b0, 5'b00000);
      dec_chk(2'h2, 2'h0, 1'b0, 5'b00001);
      // all ports hybrid with different control bits
      set_policy(32'h0002227E);
      dec_chk(2'h0, 2'h0, 1'b0, 5'b01000);
      dec_chk(2'h0, 2'h0, 1'b1, 5'b00000);
      dec_chk(2'h0, 2'h2, 1'b0, 5'b00110);
      dec_chk(2'h0, 2'h2, 1'b1, 5'b10000);
      dec_chk(2'h0, 2'h3, 1'b0, 5'b10000);
      dec_chk(2'h2, 2'h1, 1'b0, 5'b00100);
      dec_chk(2'h2, 2'h2, 1'b0, 5'b00000);
      dec_chk(2'h1, 2'h0, 1'b0, 5'b01000);
      $display("test tagging done");
      // pacing: one rate per queue, larger value gives a longer gap
      bus_wr(`EVTP_ADDR_PACE_P0Q01, 32'h00006000);
      bus_wr(`EVTP_ADDR_PACE_P0Q23, 32'h00002000);
      bus_wr(`EVTP_ADDR_PACE_P1Q01, 32'h00000002);
      bus_wr(`EVTP_ADDR_PACE_CTRL, 32'h00000001);
      rd_chk(`EVTP_ADDR_PACE_CTRL, 32'h00000001, 2'h0);
      pace_chk(0, 0);
      pace_chk(1, 3);
      pace_chk(2, 0);
      pace_chk(3, 1);
      pace_chk(4, 2);
      pace_chk(5, 0);
      // queue 1 released again: its pacer shows waiting in the status word
      q_byte_valid[1] <= 1'b1;
      @(posedge clock);
      q_byte_valid[1] <= 1'b0;
      rd_chk(`EVTP_ADDR_PACE_STAT, 32'h00000002, 2'h0);
      bus_wr(`EVTP_ADDR_PACE_CTRL, 32'h00000000);
      chk({26'h0, q_byte_ready}, 32'h3F, "ready after disable");
      $display("test pacing done");
      give_verdict();
   end
endmodule
